// [include/scc_pkg.sv]
/*
  scc_pkg: shared constants, types and helpers of the serial character and
  clock configuration block. Assumes an 8-bit register port and one core clock.
*/
package scc_pkg;

  // register offsets
  localparam logic [7:0] OFS_MATCH = 8'hf6;
  localparam logic [7:0] OFS_STATUS = 8'hf7;
  localparam logic [7:0] OFS_DATA = 8'hf8;
  localparam logic [7:0] OFS_AUX = 8'hf9;
  localparam logic [7:0] OFS_CHAR_FMT = 8'hfa;
  localparam logic [7:0] OFS_CLOCK = 8'hfb;
  localparam logic [7:0] OFS_DIV_HI = 8'hfc;
  localparam logic [7:0] OFS_DIV_LO = 8'hfd;

  // values after reset, and the aux_ctrl write mask
  localparam logic [7:0] RST_CHAR_FMT = 8'h00;
  localparam logic [7:0] RST_CLOCK = 8'h00;
  localparam logic [15:0] RST_DIV = 16'h0000;
  localparam logic [7:0] RST_AUX = 8'h00;
  localparam logic [7:0] RST_MATCH = 8'h00;
  localparam logic [7:0] AUX_WMASK = 8'ha3;

  // char_format_cfg fields
  localparam int B_ADDR_SEL = 7;
  localparam int B_PAR_KIND = 6;
  localparam int B_PAR_ON = 5;
  localparam int B_EXTRA = 4;
  // clock_cfg fields
  localparam int B_RX_EXT = 5;
  localparam int B_BG_SRC = 4;
  localparam int B_DIV_MODE = 3;
  localparam int B_ECHO = 2;
  localparam int B_LOOP = 1;
  localparam int B_STICK = 0;
  // aux_ctrl fields
  localparam int B_QUAL = 7;
  localparam int B_TX_ADDR = 5;
  localparam int B_PIN_LVL = 2;
  localparam int B_PIN_DRV = 1;
  localparam int B_PIN_VAL = 0;

  // counts
  localparam logic [5:0] TICKS_16X = 6'h10;
  localparam logic [5:0] TICKS_1X = 6'h01;
  localparam logic [15:0] DIV_MIN = 16'h0002;
  localparam logic [3:0] WL_BASE = 4'h5;
  localparam logic [5:0] STOP_16X [4] = '{6'h10, 6'h18, 6'h20, 6'h28};
  localparam logic [5:0] STOP_1X [4] = '{6'h01, 6'h02, 6'h02, 6'h03};

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_ADDR, TX_STOP} scc_tx_type;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_ADDR, RX_STOP} scc_rx_type;

  // data bits of a character
  function automatic logic [3:0] data_len(input logic [1:0] wl);
    return WL_BASE + {2'b00, wl};
  endfunction

  // stop length in bit-clock ticks
  function automatic logic [5:0] stop_ticks(input logic one_x, input logic [1:0] sel);
    return one_x ? STOP_1X[sel] : STOP_16X[sel];
  endfunction

  // parity bit over the low len data bits only
  function automatic logic par_bit(input logic [7:0] d, input logic [3:0] len,
                                   input logic even);
    logic x;
    x = ^(d & ~(8'hff << len));
    return even ? x : ~x;
  endfunction

endpackage

// [src/scc_baud_gen.sv]
/*
  scc_baud_gen: 16-bit divide-by-N generator. Assumes src_en pulses once per
  input clock event and load pulses on any divisor byte write.
*/
`timescale 1ns/1ps
module scc_baud_gen (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // control
  input wire logic src_en,
  input wire logic [15:0] divisor,
  input wire logic load,
  // outputs
  output logic tick,
  output logic level_ff
);
  import scc_pkg::*;

  logic [15:0] cnt_ff;
  logic run;

  // divisors 0 and 1 stop the generator
  // RULE16 stop on small divisor
  assign run = (divisor >= DIV_MIN);
  assign tick = run & src_en & ~load & (cnt_ff == 16'h0000);

  // down counter, restarted at once on a divisor write
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 16'h0000;
      level_ff <= 1'b0;
    end else begin
      // RULE15 immediate divisor load
      if (load) begin
        cnt_ff <= 16'h0000;
      end else if (!run) begin
        cnt_ff <= 16'h0000;
      end else if (src_en) begin
        // RULE14 divide by n
        cnt_ff <= (cnt_ff == 16'h0000) ? divisor - 16'h0001 : cnt_ff - 16'h0001;
      end
      level_ff <= run & (cnt_ff >= (divisor >> 1));
    end
  end

endmodule // scc_baud_gen

// [src/scc_bit_timer.sv]
/*
  scc_bit_timer: counts ticks within one bit cell and flags its middle and
  end. Assumes clear is held while the owning engine is idle.
*/
`timescale 1ns/1ps
module scc_bit_timer (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // control
  input wire logic tick,
  input wire logic clear,
  input wire logic [5:0] len,
  // strobes
  output logic mid,
  output logic done
);
  import scc_pkg::*;

  logic [5:0] count_ff;

  // middle and end of the cell
  assign mid = tick & ~clear & (count_ff == (len >> 1));
  assign done = tick & ~clear & (count_ff == len - 6'h01);

  // cell counter
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= 6'h00;
    end else if (clear || done) begin
      count_ff <= 6'h00;
    end else if (tick) begin
      count_ff <= count_ff + 6'h01;
    end
  end

endmodule // scc_bit_timer

// [src/scc_serial.sv]
/*
  scc_serial: character format, clock configuration, baud generator, transmit
  and receive engines with echo and loopback. Assumes an 8-bit register port
  with one-cycle strobes and serial pins synchronous to core_clk.
*/
// Local design decision: strobed register access.
// Summary of operation
// RULE1 - parity select 0 means odd, 1 means even, both directions.
// RULE2 - parity generated and checked after data, before address bit and stop.
// RULE3 - parity covers data and parity bit only, never the ninth bit.
// RULE4 - address option adds one bit between parity and first stop bit.
// RULE5 - stop field gives 1,1.5,2,2.5 bits in 16x; 1,2,2,3 in 1x.
// RULE6 - word length field gives five to eight data bits.
// RULE7 - transmit clock select: pin i/o, clock input, baud out, sync out.
// RULE8 - external receive clock drives receiver at 16x or 1x rate.
// RULE9 - baud source select picks receive-clock pin or system clock.
// RULE10 - divisor mode 1 gives 1x timing, 0 gives sixteen ticks per bit.
// RULE11 - auto echo drives serial output from serial input, receiver still runs.
// RULE12 - loopback holds output high and feeds transmitter into receiver.
// RULE13 - stick parity inverts the selected parity type in both directions.
// RULE14 - baud generator is a 16-bit divide-by-n counter, two byte registers.
// RULE15 - divisor write loads the counter immediately.
// RULE16 - divisor 0 or 1 stops the baud generator.
// RULE17 - clock configuration resets to all zeros.
// RULE18 - address select combines with the qualifier to choose detection.
// RULE19 - codes: ninth bit, match, match and ninth, match after break.
// RULE20 - in 16x the receiver samples each bit near its middle.
`timescale 1ns/1ps
module scc_serial (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // serial data pins
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  // two-way clock pin
  input wire logic clk_pin_in,
  output logic clk_pin_out,
  output logic clk_pin_oe_n,
  // external receive clock pin
  input wire logic rx_clk_pin
);
  import scc_pkg::*;

  // reset release synchroniser
  logic rst_meta_ff;
  logic rst_sync_ff;
  logic rst_n;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  assign rst_n = rst_sync_ff;

  // registers
  logic [7:0] char_fmt_ff;
  logic [7:0] clock_cfg_ff;
  logic [15:0] div_ff;
  logic [7:0] aux_ff;
  logic [7:0] match_ff;
  logic [7:0] tx_data_ff;
  logic tx_pend_ff;
  logic [7:0] rx_data_ff;
  logic [4:0] stat_ff;
  logic [7:0] rdata_ff;
  logic serial_out_ff;
  logic clk_out_ff;
  logic clk_oe_n_ff;

  // write decode
  logic wr_fmt, wr_clk, wr_hi, wr_lo, wr_aux, wr_match, wr_data, wr_stat;
  assign wr_fmt = reg_wr & (reg_addr == OFS_CHAR_FMT);
  assign wr_clk = reg_wr & (reg_addr == OFS_CLOCK);
  assign wr_hi = reg_wr & (reg_addr == OFS_DIV_HI);
  assign wr_lo = reg_wr & (reg_addr == OFS_DIV_LO);
  assign wr_aux = reg_wr & (reg_addr == OFS_AUX);
  assign wr_match = reg_wr & (reg_addr == OFS_MATCH);
  assign wr_data = reg_wr & (reg_addr == OFS_DATA);
  assign wr_stat = reg_wr & (reg_addr == OFS_STATUS);

  // configuration fields
  logic mode_1x, par_on, extra_on, loop_on, echo_on, even_eff;
  logic [1:0] tx_sel;
  logic [3:0] wlen;
  logic [5:0] bit_ticks;
  assign par_on = char_fmt_ff[B_PAR_ON];
  assign extra_on = char_fmt_ff[B_EXTRA];
  assign loop_on = clock_cfg_ff[B_LOOP];
  assign echo_on = clock_cfg_ff[B_ECHO];
  assign tx_sel = clock_cfg_ff[7:6];
  // RULE6 word length
  assign wlen = data_len(char_fmt_ff[1:0]);
  // RULE10 divisor mode
  assign mode_1x = clock_cfg_ff[B_DIV_MODE];
  assign bit_ticks = mode_1x ? TICKS_1X : TICKS_16X;
  // RULE1 parity kind
  // RULE13 stick inverts kind
  assign even_eff = char_fmt_ff[B_PAR_KIND] ^ clock_cfg_ff[B_STICK];

  // configuration registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      char_fmt_ff <= RST_CHAR_FMT;
      // RULE17 clock config clear
      clock_cfg_ff <= RST_CLOCK;
      div_ff <= RST_DIV;
      match_ff <= RST_MATCH;
    end else begin
      if (wr_fmt) char_fmt_ff <= reg_wdata;
      if (wr_clk) clock_cfg_ff <= reg_wdata;
      // RULE14 two divisor bytes
      if (wr_hi) div_ff[15:8] <= reg_wdata;
      if (wr_lo) div_ff[7:0] <= reg_wdata;
      if (wr_match) match_ff <= reg_wdata;
    end
  end

  // external clock edges; pins are already synchronous
  logic tclk_d_ff, rclk_d_ff, tclk_rise, rclk_rise;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tclk_d_ff <= 1'b0;
      rclk_d_ff <= 1'b0;
    end else begin
      tclk_d_ff <= clk_pin_in;
      rclk_d_ff <= rx_clk_pin;
    end
  end
  assign tclk_rise = clk_pin_in & ~tclk_d_ff;
  assign rclk_rise = rx_clk_pin & ~rclk_d_ff;

  // baud generator
  logic bg_src_en, baud_tick, baud_level;
  // RULE9 baud source
  assign bg_src_en = clock_cfg_ff[B_BG_SRC] ? rclk_rise : 1'b1;

  scc_baud_gen u_baud (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .src_en(bg_src_en),
    .divisor(div_ff),
    .load(wr_hi | wr_lo),
    .tick(baud_tick),
    .level_ff(baud_level)
  );

  // engine clocks
  logic tx_tick, rx_tick;
  // RULE7 transmit clock input
  assign tx_tick = (tx_sel == 2'b01) ? tclk_rise : baud_tick;
  // RULE8 external receive clock
  assign rx_tick = clock_cfg_ff[B_RX_EXT] ? rclk_rise : baud_tick;

  // transmitter
  scc_tx_type tx_state_ff;
  logic [7:0] tx_shift_ff;
  logic [3:0] tx_idx_ff;
  logic tx_par_ff, tx_addr_ff, tx_line_ff;
  logic tx_done, tx_idle, tx_load;
  logic [5:0] tx_len;
  assign tx_idle = (tx_state_ff == TX_IDLE);
  assign tx_load = tx_tick & tx_idle & tx_pend_ff;
  // RULE5 stop length
  assign tx_len = (tx_state_ff == TX_STOP) ? stop_ticks(mode_1x, char_fmt_ff[3:2]) : bit_ticks;

  scc_bit_timer u_tx_timer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .tick(tx_tick),
    .clear(tx_idle),
    .len(tx_len),
    .mid(),
    .done(tx_done)
  );

  // holding register; a new write in the load cycle is kept
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_data_ff <= 8'h00;
      tx_pend_ff <= 1'b0;
    end else begin
      if (wr_data) tx_data_ff <= reg_wdata;
      tx_pend_ff <= wr_data | (tx_pend_ff & ~tx_load);
    end
  end

  // transmit sequence, one cell per state step
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state_ff <= TX_IDLE;
      tx_shift_ff <= 8'h00;
      tx_idx_ff <= 4'h0;
      tx_par_ff <= 1'b0;
      tx_addr_ff <= 1'b0;
      tx_line_ff <= 1'b1;
    end else if (tx_load) begin
      tx_state_ff <= TX_START;
      tx_shift_ff <= tx_data_ff;
      tx_idx_ff <= 4'h0;
      // RULE3 data bits only
      tx_par_ff <= par_bit(tx_data_ff, wlen, even_eff);
      tx_addr_ff <= aux_ff[B_TX_ADDR];
      tx_line_ff <= 1'b0;
    end else if (tx_done) begin
      case (tx_state_ff)
        TX_START: begin
          tx_state_ff <= TX_DATA;
          tx_line_ff <= tx_shift_ff[0];
        end
        TX_DATA: begin
          if (tx_idx_ff == wlen - 4'h1) begin
            // RULE2 parity after data
            if (par_on) begin
              tx_state_ff <= TX_PAR;
              tx_line_ff <= tx_par_ff;
            end else if (extra_on) begin
              tx_state_ff <= TX_ADDR;
              tx_line_ff <= tx_addr_ff;
            end else begin
              tx_state_ff <= TX_STOP;
              tx_line_ff <= 1'b1;
            end
          end else begin
            tx_idx_ff <= tx_idx_ff + 4'h1;
            tx_shift_ff <= tx_shift_ff >> 1;
            tx_line_ff <= tx_shift_ff[1];
          end
        end
        TX_PAR: begin
          // RULE4 extra bit before stop
          tx_state_ff <= extra_on ? TX_ADDR : TX_STOP;
          tx_line_ff <= extra_on ? tx_addr_ff : 1'b1;
        end
        TX_ADDR: begin
          tx_state_ff <= TX_STOP;
          tx_line_ff <= 1'b1;
        end
        TX_STOP: begin
          tx_state_ff <= TX_IDLE;
          tx_line_ff <= 1'b1;
        end
        default: begin
          tx_state_ff <= TX_IDLE;
          tx_line_ff <= 1'b1;
        end
      endcase
    end
  end

  // receive input selection
  logic rx_in;
  // RULE12 loop transmitter back
  assign rx_in = loop_on ? tx_line_ff : serial_in_pin;

  // receiver
  scc_rx_type rx_state_ff;
  logic [7:0] rx_shift_ff;
  logic [3:0] rx_idx_ff;
  logic rx_par_ok_ff, rx_nine_ff, rx_zero_ff, after_brk_ff;
  logic rx_mid, rx_done, rx_idle, rx_end, last_data;
  assign rx_idle = (rx_state_ff == RX_IDLE);
  assign last_data = (rx_idx_ff == wlen - 4'h1);

  scc_bit_timer u_rx_timer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .tick(rx_tick),
    .clear(rx_idle),
    .len(bit_ticks),
    .mid(rx_mid),
    .done(rx_done)
  );

  // character end is the middle of the first stop bit
  assign rx_end = (rx_state_ff == RX_STOP) & rx_mid;

  // address detection
  logic [7:0] len_mask;
  logic rx_match, addr_event, brk_event;
  logic [1:0] addr_code;
  assign len_mask = ~(8'hff << wlen);
  assign rx_match = ((rx_shift_ff ^ match_ff) & len_mask) == 8'h00;
  // RULE18 qualifier with select
  assign addr_code = {aux_ff[B_QUAL], char_fmt_ff[B_ADDR_SEL]};
  // RULE19 detection coding
  assign addr_event = (addr_code == 2'b00) ? rx_nine_ff :
                      (addr_code == 2'b01) ? rx_match :
                      (addr_code == 2'b10) ? (rx_match & rx_nine_ff) :
                      (rx_match & after_brk_ff);
  assign brk_event = rx_zero_ff & ~rx_in;

  // receive sequence; sample at cell middle, advance at cell end, leave stop at its middle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_state_ff <= RX_IDLE;
      rx_shift_ff <= 8'hff;
      rx_idx_ff <= 4'h0;
      rx_par_ok_ff <= 1'b1;
      rx_nine_ff <= 1'b0;
      rx_zero_ff <= 1'b0;
    end else begin
      case (rx_state_ff)
        RX_IDLE: begin
          if (rx_tick && !rx_in) begin
            rx_state_ff <= mode_1x ? RX_DATA : RX_START;
            rx_shift_ff <= 8'hff;
            rx_idx_ff <= 4'h0;
            rx_par_ok_ff <= 1'b1;
            rx_nine_ff <= 1'b0;
            rx_zero_ff <= 1'b1;
          end
        end
        RX_START: begin
          // RULE20 mid-cell start check
          if (rx_mid && rx_in) begin
            rx_state_ff <= RX_IDLE;
          end else if (rx_done) begin
            rx_state_ff <= RX_DATA;
          end
        end
        RX_DATA: begin
          // RULE20 mid-cell data sample
          if (rx_mid) begin
            rx_shift_ff[rx_idx_ff[2:0]] <= rx_in;
            rx_zero_ff <= rx_zero_ff & ~rx_in;
          end
          if (rx_done) begin
            rx_idx_ff <= rx_idx_ff + 4'h1;
            if (last_data) begin
              rx_state_ff <= par_on ? RX_PAR : (extra_on ? RX_ADDR : RX_STOP);
            end
          end
        end
        RX_PAR: begin
          // RULE2 check received parity
          if (rx_mid) begin
            rx_par_ok_ff <= (rx_in == par_bit(rx_shift_ff, wlen, even_eff));
            rx_zero_ff <= rx_zero_ff & ~rx_in;
          end
          if (rx_done) rx_state_ff <= extra_on ? RX_ADDR : RX_STOP;
        end
        RX_ADDR: begin
          // RULE4 capture ninth bit
          if (rx_mid) begin
            rx_nine_ff <= rx_in;
            rx_zero_ff <= rx_zero_ff & ~rx_in;
          end
          if (rx_done) rx_state_ff <= RX_STOP;
        end
        RX_STOP: begin
          if (rx_mid) rx_state_ff <= RX_IDLE;
        end
        default: rx_state_ff <= RX_IDLE;
      endcase
    end
  end

  // received character and break memory
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_data_ff <= 8'hff;
      after_brk_ff <= 1'b0;
    end else if (rx_end) begin
      rx_data_ff <= rx_shift_ff;
      after_brk_ff <= brk_event;
    end
  end

  // sticky status; hardware set wins over a clearing write
  logic [4:0] stat_set, stat_clr;
  assign stat_set = rx_end ? {brk_event, addr_event, ~rx_in, par_on & ~rx_par_ok_ff, 1'b1}
                           : 5'h00;
  assign stat_clr = wr_stat ? ~reg_wdata[4:0] : 5'h00;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_ff <= 5'h00;
      aux_ff <= RST_AUX;
    end else begin
      stat_ff <= (stat_ff & ~stat_clr) | stat_set;
      // address bit to send is dropped once taken, unless rewritten
      if (wr_aux) begin
        aux_ff <= reg_wdata & AUX_WMASK;
      end else if (tx_load) begin
        aux_ff[B_TX_ADDR] <= 1'b0;
      end
    end
  end

  // read selection; unmapped offsets read zero
  logic [7:0] rd_val, aux_rd;
  assign aux_rd = (aux_ff & AUX_WMASK) | ({7'h00, clk_pin_in} << B_PIN_LVL);
  assign rd_val = (reg_addr == OFS_CHAR_FMT) ? char_fmt_ff :
                  (reg_addr == OFS_CLOCK) ? clock_cfg_ff :
                  (reg_addr == OFS_DIV_HI) ? div_ff[15:8] :
                  (reg_addr == OFS_DIV_LO) ? div_ff[7:0] :
                  (reg_addr == OFS_AUX) ? aux_rd :
                  (reg_addr == OFS_MATCH) ? match_ff :
                  (reg_addr == OFS_DATA) ? rx_data_ff :
                  (reg_addr == OFS_STATUS) ? {1'b0, tx_idle, ~tx_pend_ff, stat_ff} :
                  8'h00;

  // read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= reg_rd ? rd_val : 8'h00;
    end
  end
  assign reg_rdata = rdata_ff;

  // output pins, registered to keep them glitch free
  logic nxt_serial_out, nxt_clk_out, nxt_clk_oe_n;
  // RULE12 loopback holds output high
  // RULE11 echo input to output
  assign nxt_serial_out = loop_on ? 1'b1 : (echo_on ? serial_in_pin : tx_line_ff);
  // RULE7 clock pin function
  assign nxt_clk_oe_n = (tx_sel == 2'b00) ? ~aux_ff[B_PIN_DRV] : (tx_sel == 2'b01);
  assign nxt_clk_out = (tx_sel == 2'b00) ? aux_ff[B_PIN_VAL] :
                       (tx_sel == 2'b10) ? baud_level :
                       (tx_sel == 2'b11) ? (tx_idle | baud_level) : 1'b0;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_out_ff <= 1'b1;
      clk_out_ff <= 1'b0;
      clk_oe_n_ff <= 1'b1;
    end else begin
      serial_out_ff <= nxt_serial_out;
      clk_out_ff <= nxt_clk_out;
      clk_oe_n_ff <= nxt_clk_oe_n;
    end
  end
  assign serial_out_pin = serial_out_ff;
  assign clk_pin_out = clk_out_ff;
  assign clk_pin_oe_n = clk_oe_n_ff;

endmodule // scc_serial

// [bench/scc_serial_props.sv]
/* scc_serial_props: port checker for scc_serial.
   Assumes a bind to scc_serial and writes only through the register port. */
`timescale 1ns/1ps
module scc_serial_props (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // pins
  input wire logic serial_in_pin,
  input wire logic serial_out_pin,
  input wire logic clk_pin_out,
  input wire logic clk_pin_oe_n
);
  import scc_pkg::*;
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  logic [7:0] ccr_ff;
  logic [7:0] aux_ff;
  logic [15:0] div_ff;
  logic [15:0] gap_ff;
  logic [1:0] q_ff;
  logic [1:0] seen_ff;
  logic pin_ff;
  // calm: three cycles since any write, so registered outputs have settled
  wire rise = clk_pin_out & ~pin_ff;
  wire calm = q_ff == 2'h3;
  wire baud_out = calm && ccr_ff[7:6] == 2'h2 && !ccr_ff[B_BG_SRC];
  wire echo = calm && ccr_ff[B_ECHO] && !ccr_ff[B_LOOP];
  // shadows of writes; first two rises after a write may follow a mode change, skip them
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ccr_ff <= 8'h00;
      aux_ff <= 8'h00;
      div_ff <= 16'h0000;
      gap_ff <= 16'h0000;
      q_ff <= 2'h0;
      seen_ff <= 2'h0;
      pin_ff <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == OFS_CLOCK) ccr_ff <= reg_wdata;
      if (reg_wr && reg_addr == OFS_AUX) aux_ff <= reg_wdata;
      if (reg_wr && reg_addr == OFS_DIV_HI) div_ff[15:8] <= reg_wdata;
      if (reg_wr && reg_addr == OFS_DIV_LO) div_ff[7:0] <= reg_wdata;
      q_ff <= reg_wr ? 2'h0 : (calm ? q_ff : q_ff + 2'h1);
      pin_ff <= clk_pin_out;
      gap_ff <= rise ? 16'h0001 : gap_ff + 16'h0001;
      seen_ff <= reg_wr ? 2'h0 : ((rise && seen_ff != 2'h2) ? seen_ff + 2'h1 : seen_ff);
    end
  end
  // register, echo, loopback and clock pin relations
  property p_rd_ccr; reg_rd && reg_addr == OFS_CLOCK |=> reg_rdata == ccr_ff; endproperty
  a_rd_ccr: assert property (p_rd_ccr) else $error("clock_cfg readback");
  property p_echo; echo |-> serial_out_pin == $past(serial_in_pin); endproperty
  a_echo: assert property (p_echo) else $error("echo path");
  property p_loop; calm && ccr_ff[B_LOOP] |-> serial_out_pin; endproperty
  a_loop: assert property (p_loop) else $error("loopback output");
  property p_gpio; calm && ccr_ff[7:6] == 2'h0 |->
    clk_pin_oe_n == !aux_ff[B_PIN_DRV] && clk_pin_out == aux_ff[B_PIN_VAL]; endproperty
  a_gpio: assert property (p_gpio) else $error("clock pin io");
  property p_pin_in; calm && ccr_ff[7:6] == 2'h1 |-> clk_pin_oe_n; endproperty
  a_pin_in: assert property (p_pin_in) else $error("clock pin input");
  property p_pin_out; calm && ccr_ff[7] |-> !clk_pin_oe_n; endproperty
  a_pin_out: assert property (p_pin_out) else $error("clock pin output");
  property p_period; baud_out && seen_ff == 2'h2 && rise && div_ff >= DIV_MIN |->
    gap_ff == div_ff; endproperty
  a_period: assert property (p_period) else $error("baud period");
  property p_stop; baud_out && div_ff < DIV_MIN |=> $stable(clk_pin_out); endproperty
  a_stop: assert property (p_stop) else $error("baud not stopped");
endmodule // scc_serial_props

bind scc_serial scc_serial_props u_props (.*);

// [bench/scc_remote.sv]
/* scc_remote: far-side serial transceiver, sends and captures 12-cell frames.
   Assumes cells of cyc core clocks; the line idles high as with a pull-up. */
`timescale 1ns/1ps
module scc_remote (
  // clock
  input wire logic core_clk,
  // serial lines
  input wire logic line_in,
  output logic line_out
);
  initial line_out = 1'b1;
  // cells at the device bit rate
  task automatic send(input logic [11:0] f, input int cyc);
    for (int i = 0; i < 12; i++) begin
      line_out <= f[i];
      repeat (cyc) @(posedge core_clk);
    end
  endtask
  // start edge search is bounded; samples mid-cell
  task automatic grab(input int cyc, output logic [11:0] f);
    int n;
    n = 0;
    while (line_in !== 1'b0 && n < 2000) begin
      @(posedge core_clk);
      n++;
    end
    repeat (cyc / 2) @(posedge core_clk);
    for (int i = 0; i < 12; i++) begin
      f[i] = line_in;
      repeat (cyc) @(posedge core_clk);
    end
  endtask
endmodule // scc_remote

// [bench/tb_top.sv]
/* tb_top: register-level tests of scc_serial with a remote transceiver.
   Assumes divisor 2 from the system clock for all frames. */
`timescale 1ns/1ps
module tb_top;
  import scc_pkg::*;
  logic core_clk, arst_n, reg_wr, reg_rd, serial_in_pin, serial_out_pin;
  logic clk_pin_out, clk_pin_oe_n;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
  logic [11:0] fr;
  int fails = 0;
  int checks = 0;
  int cyc_n = 0;
  localparam logic [7:0] TCHR [5] = '{8'h20, 8'h63, 8'h21, 8'h72, 8'h03};
  localparam logic [7:0] TCCR [5] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h08};
  localparam logic [7:0] TAUX [5] = '{8'h00, 8'h00, 8'h00, 8'h20, 8'h00};
  localparam logic [7:0] TDAT [5] = '{8'h13, 8'ha5, 8'h2d, 8'h55, 8'h96};
  scc_serial uut (.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin), .clk_pin_in(1'b0),
    .clk_pin_out(clk_pin_out), .clk_pin_oe_n(clk_pin_oe_n), .rx_clk_pin(1'b0));
  scc_remote u_rem (.core_clk(core_clk), .line_in(serial_out_pin), .line_out(serial_in_pin));
  // 40 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // hang guard, well above the expected run
  always @(posedge core_clk) begin
    cyc_n++;
    if (cyc_n == 60000) begin
      fails++;
      end_sim();
    end
  end
  task automatic end_sim;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if (got !== exp) begin
      $display("[ERR] %s exp %h got %h", n, exp, got);
      fails++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // read data is taken in the one cycle it stands
  task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    v = reg_rdata;
    chk(n, {4'h0, v}, {4'h0, exp});
  endtask
  // expected line cells: start, data lsb first, parity, extra bit, then high
  function automatic logic [11:0] frm(logic [7:0] chr, clock_cfg, aux, d);
    logic [11:0] f;
    int n;
    logic p;
    f = 12'hffe;
    n = 5 + chr[1:0];
    p = ^(d & ~(8'hff << n));
    for (int k = 0; k < n; k++) f[k + 1] = d[k];
    if (chr[5]) f[n + 1] = p ^ ~(chr[6] ^ clock_cfg[0]);
    if (chr[4]) f[n + 1 + chr[5]] = aux[5];
    return f;
  endfunction
  initial begin
    arst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    rchk("clock_cfg", OFS_CLOCK, 8'h00);
    rchk("unmapped", 8'h10, 8'h00);
    wr(OFS_DIV_HI, 8'h00);
    wr(OFS_DIV_LO, 8'h02);
    rchk("div_lo", OFS_DIV_LO, 8'h02);
    $display("test regs done");
    for (int i = 0; i < 5; i++) begin
      wr(OFS_CHAR_FMT, TCHR[i]);
      wr(OFS_CLOCK, TCCR[i]);
      wr(OFS_AUX, TAUX[i]);
      wr(OFS_DATA, TDAT[i]);
      u_rem.grab(TCCR[i][3] ? 2 : 32, fr);
      chk("tx frame", fr, frm(TCHR[i], TCCR[i], TAUX[i], TDAT[i]));
    end
    $display("test tx done");
    wr(OFS_CLOCK, 8'h00);
    wr(OFS_CHAR_FMT, 8'he3);
    wr(OFS_MATCH, 8'h3c);
    wr(OFS_STATUS, 8'h00);
    u_rem.send(frm(8'h63, 8'h00, 8'h00, 8'h3c), 32);
    rchk("rx data", OFS_DATA, 8'h3c);
    rchk("rx status", OFS_STATUS, 8'h69);
    wr(OFS_CHAR_FMT, 8'h20);
    wr(OFS_STATUS, 8'h00);
    u_rem.send(frm(8'h20, 8'h00, 8'h00, 8'h0b) ^ 12'h040, 32);
    rchk("rx short data", OFS_DATA, 8'heb);
    rchk("rx parity err", OFS_STATUS, 8'h63);
    $display("test rx done");
    wr(OFS_CHAR_FMT, 8'h03);
    wr(OFS_CLOCK, 8'h02);
    wr(OFS_DATA, 8'h5a);
    repeat (400) @(posedge core_clk);
    rchk("loop data", OFS_DATA, 8'h5a);
    wr(OFS_CLOCK, 8'h04);
    wr(OFS_AUX, 8'h03);
    u_rem.send(frm(8'h03, 8'h00, 8'h00, 8'hc3), 32);
    rchk("echo rx data", OFS_DATA, 8'hc3);
    $display("test loop echo done");
    wr(OFS_CLOCK, 8'h40);
    repeat (4) @(posedge core_clk);
    chk("pin input", {11'h0, clk_pin_oe_n}, 12'h001);
    wr(OFS_CLOCK, 8'h80);
    wr(OFS_DIV_LO, 8'h04);
    repeat (40) @(posedge core_clk);
    wr(OFS_DIV_LO, 8'h00);
    repeat (20) @(posedge core_clk);
    $display("test clock pin done");
    end_sim();
  end
endmodule // tb_top
